// ### hdl/capture_unit.sv
// One input-capture channel: edge detection and counter latch
`timescale 1ns/100ps
module capture_unit
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pin and edge choice
    input wire logic pin,
    input wire logic rising_sel,
    // Counter and result
    input wire logic [15:0] counter,
    output logic capture_event,
    output logic [15:0] captured
);

    logic pin_prev;
    wire rising_seen = pin & ~pin_prev;
    wire falling_seen = ~pin & pin_prev;
    wire edge_seen = rising_sel ? rising_seen : falling_seen;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= pin;
        end
    end

    assign capture_event = edge_seen;

    // Captured value has no reset: undefined until the first edge
    always_ff @(posedge clk) begin
        if (edge_seen) begin
            captured <= counter;
        end
    end

endmodule : capture_unit

// ### hdl/timer_data_regs.sv
// Timer data-register bank, flag clearing and shared interrupt request
// What this block does
// - One capture enable covers both capture flags, even if pin two is output.
// - New shared request only after all flags have been clear together or global select was clear.
// - Flag clears by status access then access to its data low byte.
// - Capture event latches counter into read-only high and low bytes.
// - Counter and alternate view reset to FFh high, FCh low.
// - Counter low write reinitialises counter; access after status clears overflow.
// - Alternate view mirrors counter; its low write reinitialises but keeps overflow.
// - Two compare values, read/write bytes, high reset 80h, low 00h.
// - Status masks: capture one 128, compare one 64, overflow 32, two 16, 8.
// - Three control, one status and six data register pairs per timer.
// - Overflow flag sets when counter wraps from maximum to zero.
// - With capture enable and global select set, either capture flag requests an interrupt.
`timescale 1ns/100ps
module timer_data_regs
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register file port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Timer inputs
    input wire logic count_tick,
    input wire logic capture_pin_one,
    input wire logic capture_pin_two,
    // Shared interrupt channel
    output logic timer_irq
);

    // ========================================
    // State
    logic [15:0] counter;
    logic [7:0] first_control_register;
    logic [7:0] second_control_register;
    logic [7:0] third_control_register;
    logic [7:0] compare_hi [2];
    logic [7:0] compare_lo [2];
    logic [1:0] compare_inhibit;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] clear_armed;
    logic [15:0] captured [2];
    logic [1:0] capture_event;
    logic [1:0] compare_event;

    // ========================================
    // Address decode
    wire access = reg_rd | reg_wr;
    wire hit_cap1_lo = access && (reg_addr == ADDR_CAP1_LO);
    wire hit_cap2_lo = access && (reg_addr == ADDR_CAP2_LO);
    wire hit_cnt_lo = access && (reg_addr == ADDR_CNT_LO);
    wire hit_alt_lo = access && (reg_addr == ADDR_ALT_LO);
    wire hit_cmp1_lo = access && (reg_addr == ADDR_CMP1_LO);
    wire hit_cmp2_lo = access && (reg_addr == ADDR_CMP2_LO);
    wire hit_flags = access && (reg_addr == ADDR_FLAGS);
    wire wr_cnt_lo = reg_wr && (reg_addr == ADDR_CNT_LO);
    wire wr_alt_lo = reg_wr && (reg_addr == ADDR_ALT_LO);
    wire wr_ctrl1 = reg_wr && (reg_addr == ADDR_CTRL1);
    wire wr_ctrl2 = reg_wr && (reg_addr == ADDR_CTRL2);
    wire wr_ctrl3 = reg_wr && (reg_addr == ADDR_CTRL3);
    wire [1:0] wr_cmp_hi = {reg_wr && (reg_addr == ADDR_CMP2_HI),
                            reg_wr && (reg_addr == ADDR_CMP1_HI)};
    wire [1:0] wr_cmp_lo = {reg_wr && (reg_addr == ADDR_CMP2_LO),
                            reg_wr && (reg_addr == ADDR_CMP1_LO)};

    // ========================================
    // Control bits
    wire capture_irq_enable = first_control_register[CTRL1_CAPTURE_IE];
    wire compare_irq_enable = first_control_register[CTRL1_COMPARE_IE];
    wire overflow_irq_enable = first_control_register[CTRL1_OVERFLOW_IE];
    wire global_irq_select = third_control_register[CTRL3_GLOBAL_SEL];
    wire [1:0] capture_rising = {second_control_register[CTRL2_EDGE_TWO],
                                 first_control_register[CTRL1_EDGE_ONE]};

    // ========================================
    // Free-running counter
    wire counter_reinit = wr_cnt_lo | wr_alt_lo;
    wire [15:0] counter_inc = 16'(counter + 16'h0001);
    wire overflow_event = count_tick && !counter_reinit && (counter == COUNTER_MAX);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            counter <= COUNTER_RESET;
        end else if (counter_reinit) begin
            counter <= COUNTER_RESET;
        end else if (count_tick) begin
            counter <= counter_inc;
        end
    end

    // ========================================
    // Control registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_control_register <= CTRL_RESET;
            second_control_register <= CTRL_RESET;
            third_control_register <= CTRL_RESET;
        end else begin
            if (wr_ctrl1) begin
                first_control_register <= reg_wdata;
            end
            if (wr_ctrl2) begin
                second_control_register <= reg_wdata;
            end
            if (wr_ctrl3) begin
                third_control_register <= reg_wdata & CTRL3_USED_MASK;
            end
        end
    end

    // ========================================
    // Capture and compare channels
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            capture_unit u_capture (
                .clk(clk),
                .reset_n(reset_n),
                .pin(ch == 0 ? capture_pin_one : capture_pin_two),
                .rising_sel(capture_rising[ch]),
                .counter(counter),
                .capture_event(capture_event[ch]),
                .captured(captured[ch])
            );

            // Match on the tick that brings the counter to the compare value
            assign compare_event[ch] = count_tick && !counter_reinit && !compare_inhibit[ch]
                && (counter_inc == {compare_hi[ch], compare_lo[ch]});

            // Writing the high byte holds off compares until the low byte follows
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    compare_hi[ch] <= COMPARE_HI_RESET;
                    compare_lo[ch] <= COMPARE_LO_RESET;
                    compare_inhibit[ch] <= 1'b0;
                end else if (wr_cmp_hi[ch]) begin
                    compare_hi[ch] <= reg_wdata;
                    compare_inhibit[ch] <= 1'b1;
                end else if (wr_cmp_lo[ch]) begin
                    compare_lo[ch] <= reg_wdata;
                    compare_inhibit[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    // ========================================
    // Flags and two-step clearing
    wire [NUM_FLAGS-1:0] set_event = {capture_event[0], compare_event[0], overflow_event,
                                      capture_event[1], compare_event[1]};
    // Alternate low byte is deliberately absent from the overflow clear
    wire [NUM_FLAGS-1:0] clear_access = {hit_cap1_lo, hit_cmp1_lo, hit_cnt_lo,
                                         hit_cap2_lo, hit_cmp2_lo};

    genvar fi;
    generate
        for (fi = 0; fi < NUM_FLAGS; fi++) begin : g_flag
            wire clear_now = clear_armed[fi] & clear_access[fi];
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    flags[fi] <= 1'b0;
                    clear_armed[fi] <= 1'b0;
                end else begin
                    // A new event wins over a clear in the same cycle
                    flags[fi] <= set_event[fi] | (flags[fi] & ~clear_now);
                    if (hit_flags) begin
                        clear_armed[fi] <= flags[fi];
                    end else if (clear_access[fi]) begin
                        clear_armed[fi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    wire [7:0] status_byte = {flags, FLAGS_RESERVED};

    // ========================================
    // Shared interrupt request
    wire [NUM_FLAGS-1:0] enabled_flags = flags & {capture_irq_enable, compare_irq_enable,
        overflow_irq_enable, capture_irq_enable, compare_irq_enable};
    // Once raised, the request holds until every flag is clear at once or the global select clears
    wire next_irq = global_irq_select
        && (timer_irq ? (|flags) : (|enabled_flags));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= next_irq;
        end
    end

    // ========================================
    // Read data
    wire [7:0] next_rdata =
        (reg_addr == ADDR_CAP1_HI) ? captured[0][15:8] :
        (reg_addr == ADDR_CAP1_LO) ? captured[0][7:0] :
        (reg_addr == ADDR_CAP2_HI) ? captured[1][15:8] :
        (reg_addr == ADDR_CAP2_LO) ? captured[1][7:0] :
        (reg_addr == ADDR_CNT_HI) ? counter[15:8] :
        (reg_addr == ADDR_CNT_LO) ? counter[7:0] :
        (reg_addr == ADDR_ALT_HI) ? counter[15:8] :
        (reg_addr == ADDR_ALT_LO) ? counter[7:0] :
        (reg_addr == ADDR_CMP1_HI) ? compare_hi[0] :
        (reg_addr == ADDR_CMP1_LO) ? compare_lo[0] :
        (reg_addr == ADDR_CMP2_HI) ? compare_hi[1] :
        (reg_addr == ADDR_CMP2_LO) ? compare_lo[1] :
        (reg_addr == ADDR_CTRL1) ? first_control_register :
        (reg_addr == ADDR_CTRL2) ? second_control_register :
        (reg_addr == ADDR_FLAGS) ? status_byte :
        third_control_register;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= READ_IDLE;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ========================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_capture_two_irq;
        !timer_irq && global_irq_select && capture_irq_enable && flags[FLAG_CAP2]
            |=> timer_irq;
    endproperty
    a_capture_two_irq: assert property (p_capture_two_irq)
        else $error("capture two flag did not raise request");

    property p_capture_one_irq;
        !timer_irq && global_irq_select && capture_irq_enable && flags[FLAG_CAP1]
            |=> timer_irq;
    endproperty
    a_capture_one_irq: assert property (p_capture_one_irq)
        else $error("capture one flag did not raise request");

    property p_irq_hold;
        timer_irq && global_irq_select && (|flags) |=> timer_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("request dropped before flags all cleared");

    property p_irq_gate;
        !global_irq_select |=> !timer_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request seen without global select");

    property p_clear_needs_arm;
        $fell(flags[FLAG_CAP1]) |-> $past(clear_armed[FLAG_CAP1] && hit_cap1_lo);
    endproperty
    a_clear_needs_arm: assert property (p_clear_needs_arm)
        else $error("capture one flag cleared without two-step access");

    property p_arm_only_set;
        hit_flags && !flags[FLAG_CMP1] |=> !clear_armed[FLAG_CMP1];
    endproperty
    a_arm_only_set: assert property (p_arm_only_set)
        else $error("clear armed for a flag that was not set");

    property p_capture_latch;
        capture_event[1] |=> captured[1] == $past(counter);
    endproperty
    a_capture_latch: assert property (p_capture_latch)
        else $error("capture two did not latch the counter");

    property p_counter_reinit;
        wr_cnt_lo |=> counter == COUNTER_RESET;
    endproperty
    a_counter_reinit: assert property (p_counter_reinit)
        else $error("counter low write did not reinitialise");

    property p_alt_keeps_overflow;
        hit_alt_lo && flags[FLAG_OVF] && clear_armed[FLAG_OVF] |=> flags[FLAG_OVF];
    endproperty
    a_alt_keeps_overflow: assert property (p_alt_keeps_overflow)
        else $error("alternate low access cleared overflow");

    property p_status_read;
        reg_rd && reg_addr == ADDR_FLAGS |=> reg_rdata == {$past(flags), FLAGS_RESERVED};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status byte layout wrong");

    property p_overflow_set;
        overflow_event |=> flags[FLAG_OVF] && counter == 16'h0000;
    endproperty
    a_overflow_set: assert property (p_overflow_set)
        else $error("wrap did not set overflow flag");

    property p_compare_write;
        wr_cmp_hi[0] |=> compare_hi[0] == $past(reg_wdata) && compare_inhibit[0];
    endproperty
    a_compare_write: assert property (p_compare_write)
        else $error("compare high write not stored");

    c_shared_irq: cover property ($rose(timer_irq));
    c_overflow_clear: cover property (hit_flags ##[1:8] hit_cnt_lo ##1 !flags[FLAG_OVF]);
    c_capture_both: cover property (capture_event[0] ##[1:20] capture_event[1]);
    c_irq_release: cover property ($fell(timer_irq) && global_irq_select);

endmodule : timer_data_regs

// ### hdl/timer_pkg.sv
// Constants shared by the timer data-register bank
package timer_pkg;

    // ========================================
    // Register offsets on register-file page 28
    localparam logic [7:0] ADDR_CAP1_HI = 8'hf0;
    localparam logic [7:0] ADDR_CAP1_LO = 8'hf1;
    localparam logic [7:0] ADDR_CAP2_HI = 8'hf2;
    localparam logic [7:0] ADDR_CAP2_LO = 8'hf3;
    localparam logic [7:0] ADDR_CNT_HI = 8'hf4;
    localparam logic [7:0] ADDR_CNT_LO = 8'hf5;
    localparam logic [7:0] ADDR_ALT_HI = 8'hf6;
    localparam logic [7:0] ADDR_ALT_LO = 8'hf7;
    localparam logic [7:0] ADDR_CMP1_HI = 8'hf8;
    localparam logic [7:0] ADDR_CMP1_LO = 8'hf9;
    localparam logic [7:0] ADDR_CMP2_HI = 8'hfa;
    localparam logic [7:0] ADDR_CMP2_LO = 8'hfb;
    localparam logic [7:0] ADDR_CTRL1 = 8'hfc;
    localparam logic [7:0] ADDR_CTRL2 = 8'hfd;
    localparam logic [7:0] ADDR_FLAGS = 8'hfe;
    localparam logic [7:0] ADDR_CTRL3 = 8'hff;

    // ========================================
    // Field positions
    localparam int CTRL1_CAPTURE_IE = 7;
    localparam int CTRL1_COMPARE_IE = 6;
    localparam int CTRL1_OVERFLOW_IE = 5;
    localparam int CTRL1_EDGE_ONE = 1;
    localparam int CTRL2_EDGE_TWO = 1;
    localparam int CTRL3_GLOBAL_SEL = 0;

    // Flag vector index; status byte is {flags, 3'b000}
    localparam int FLAG_CAP1 = 4;
    localparam int FLAG_CMP1 = 3;
    localparam int FLAG_OVF = 2;
    localparam int FLAG_CAP2 = 1;
    localparam int FLAG_CMP2 = 0;
    localparam int NUM_FLAGS = 5;
    localparam logic [2:0] FLAGS_RESERVED = 3'h0;

    // ========================================
    // Reset values
    localparam logic [15:0] COUNTER_RESET = 16'hfffc;
    localparam logic [15:0] COUNTER_MAX = 16'hffff;
    localparam logic [7:0] COMPARE_HI_RESET = 8'h80;
    localparam logic [7:0] COMPARE_LO_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL3_USED_MASK = 8'h0f;
    localparam logic [7:0] READ_IDLE = 8'h00;

endpackage : timer_pkg

// ### tb/core_model.sv
// Processor core and interrupt controller model facing the timer bank
`timescale 1ns/100ps
module core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register file port
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Shared interrupt channel
    input wire logic timer_irq,
    output int irq_edges
);
    logic irq_last;

    initial begin
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    // ========================================
    // Rising-edge trigger of the shared external channel
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_last <= 1'b0;
            irq_edges <= 0;
        end else begin
            irq_last <= timer_irq;
            if (timer_irq && !irq_last) begin
                irq_edges <= irq_edges + 1;
            end
        end
    end

    // ========================================
    // Byte accesses; released lines show the inverse of the last value
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
endmodule : core_model

// ### tb/timer_data_regs_tb.sv
// Self-checking bench of the timer data-register bank
`timescale 1ns/100ps
module timer_data_regs_tb;
    import timer_pkg::*;
    logic clk;
    logic reset_n;
    logic count_tick;
    logic pin_one;
    logic pin_two;
    logic [7:0] reg_addr;
    logic reg_rd;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic timer_irq;
    int irq_edges;
    int bad_count;
    int tests_run;
    int cycles;

    timer_data_regs dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .count_tick(count_tick),
        .capture_pin_one(pin_one), .capture_pin_two(pin_two), .timer_irq(timer_irq));
    core_model core_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_irq(timer_irq),
        .irq_edges(irq_edges));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ========================================
    // Reporting
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask : chk1

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        core_u.rd(a, d);
        chk8($sformatf("reg %h", a), exp, d);
    endtask : rchk

    task automatic ticks(input int n);
        @(posedge clk);
        count_tick <= 1'b1;
        repeat (n) @(posedge clk);
        count_tick <= 1'b0;
    endtask : ticks

    task automatic set_pin(input int which, input logic v);
        @(posedge clk);
        if (which == 1) pin_one <= v;
        else pin_two <= v;
        repeat (3) @(posedge clk);
    endtask : set_pin

    // ========================================
    // Scenarios
    task automatic test_reset_values();
        rchk(ADDR_CNT_HI, 8'hff);
        rchk(ADDR_CNT_LO, 8'hfc);
        rchk(ADDR_ALT_HI, 8'hff);
        rchk(ADDR_ALT_LO, 8'hfc);
        rchk(ADDR_CMP1_HI, 8'h80);
        rchk(ADDR_CMP1_LO, 8'h00);
        rchk(ADDR_CMP2_HI, 8'h80);
        rchk(ADDR_CMP2_LO, 8'h00);
        rchk(ADDR_FLAGS, 8'h00);
        chk1("timer_irq", 1'b0, timer_irq);
    endtask : test_reset_values

    task automatic test_overflow();
        core_u.wr(ADDR_CNT_LO, 8'h55);
        ticks(4);
        rchk(ADDR_CNT_HI, 8'h00);
        rchk(ADDR_CNT_LO, 8'h00);
        rchk(ADDR_FLAGS, 8'h20);
        rchk(ADDR_ALT_LO, 8'h00);
        rchk(ADDR_FLAGS, 8'h20);
        rchk(ADDR_CNT_LO, 8'h00);
        rchk(ADDR_FLAGS, 8'h00);
        core_u.wr(ADDR_CNT_HI, 8'h12);
        core_u.wr(ADDR_ALT_LO, 8'h34);
        rchk(ADDR_ALT_HI, 8'hff);
        rchk(ADDR_CNT_LO, 8'hfc);
    endtask : test_overflow

    task automatic test_compare_irq();
        core_u.wr(ADDR_CMP1_HI, 8'h00);
        core_u.wr(ADDR_CMP1_LO, 8'h02);
        core_u.wr(ADDR_CMP2_HI, 8'h00);
        core_u.wr(ADDR_CMP2_LO, 8'h03);
        rchk(ADDR_CMP1_LO, 8'h02);
        rchk(ADDR_CMP2_HI, 8'h00);
        core_u.wr(ADDR_CTRL1, 8'h40);
        ticks(7);
        rchk(ADDR_FLAGS, 8'h68);
        chk1("timer_irq", 1'b0, timer_irq);
        core_u.wr(ADDR_CTRL3, 8'h01);
        rchk(ADDR_FLAGS, 8'h68);
        chk1("timer_irq", 1'b1, timer_irq);
        rchk(ADDR_CMP1_LO, 8'h02);
        rchk(ADDR_CMP2_LO, 8'h03);
        rchk(ADDR_FLAGS, 8'h20);
        chk1("timer_irq", 1'b1, timer_irq);
        rchk(ADDR_CNT_LO, 8'h03);
        rchk(ADDR_FLAGS, 8'h00);
        chk1("timer_irq", 1'b0, timer_irq);
        chk8("irq edges", 8'd1, irq_edges[7:0]);
    endtask : test_compare_irq

    task automatic test_capture_irq();
        core_u.wr(ADDR_CTRL1, 8'h82);
        core_u.wr(ADDR_CTRL2, 8'h02);
        set_pin(1, 1'b1);
        chk1("timer_irq", 1'b1, timer_irq);
        rchk(ADDR_CAP1_HI, 8'h00);
        rchk(ADDR_CAP1_LO, 8'h03);
        core_u.wr(ADDR_CNT_LO, 8'h00);
        set_pin(2, 1'b1);
        rchk(ADDR_CAP2_HI, 8'hff);
        rchk(ADDR_CAP2_LO, 8'hfc);
        rchk(ADDR_FLAGS, 8'h90);
        rchk(ADDR_CAP1_LO, 8'h03);
        rchk(ADDR_FLAGS, 8'h10);
        chk1("timer_irq", 1'b1, timer_irq);
        rchk(ADDR_CAP2_LO, 8'hfc);
        rchk(ADDR_FLAGS, 8'h00);
        chk1("timer_irq", 1'b0, timer_irq);
        set_pin(1, 1'b0);
        set_pin(1, 1'b1);
        rchk(ADDR_CAP1_LO, 8'hfc);
        rchk(ADDR_FLAGS, 8'h80);
        rchk(ADDR_CAP1_LO, 8'hfc);
        rchk(ADDR_FLAGS, 8'h00);
        chk8("irq edges", 8'd3, irq_edges[7:0]);
    endtask : test_capture_irq

    // Pin two alone on a falling edge raises the shared request
    task automatic test_capture_two_alone();
        core_u.wr(ADDR_CTRL2, 8'h00);
        ticks(2);
        set_pin(2, 1'b0);
        chk1("timer_irq", 1'b1, timer_irq);
        rchk(ADDR_CAP2_HI, 8'hff);
        rchk(ADDR_CAP2_LO, 8'hfe);
        rchk(ADDR_FLAGS, 8'h10);
        rchk(ADDR_CAP2_LO, 8'hfe);
        rchk(ADDR_FLAGS, 8'h00);
        chk1("timer_irq", 1'b0, timer_irq);
    endtask : test_capture_two_alone

    // Overflow alone requests; a high-byte compare write holds off its match
    task automatic test_overflow_irq();
        core_u.wr(ADDR_CTRL1, 8'h20);
        ticks(2);
        rchk(ADDR_FLAGS, 8'h20);
        chk1("timer_irq", 1'b1, timer_irq);
        rchk(ADDR_CNT_LO, 8'h00);
        core_u.wr(ADDR_CMP1_HI, 8'h00);
        ticks(3);
        rchk(ADDR_FLAGS, 8'h08);
        chk1("timer_irq", 1'b0, timer_irq);
        rchk(ADDR_CMP2_LO, 8'h03);
        rchk(ADDR_FLAGS, 8'h00);
        chk8("irq edges", 8'h05, irq_edges[7:0]);
    endtask : test_overflow_irq

    // ========================================
    // Time limit
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 5000) begin
            bad_count++;
            $display("MISMATCH timeout expected finish seen hang");
            wrap_up();
        end
    end

    initial begin
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        reset_n = 1'b0;
        count_tick = 1'b0;
        pin_one = 1'b0;
        pin_two = 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        test_reset_values();
        test_overflow();
        test_compare_irq();
        test_capture_irq();
        test_capture_two_alone();
        test_overflow_irq();
        wrap_up();
    end
endmodule : timer_data_regs_tb
